// ### hdl/dmrb_cfg.svh
/*
 * register numbers, field positions, reset values and timing counts
 * of the drive monitor register bank.
 * assumes it is included by bare name wherever these are needed.
 */
`ifndef DMRB_CFG_SVH
`define DMRB_CFG_SVH

// register numbers seen by the master
`define DMRB_ADDR_RUN_STATUS 16'h0020
`define DMRB_ADDR_FAULT_FLAGS 16'h0021
`define DMRB_ADDR_LINK_STATUS 16'h0022
`define DMRB_ADDR_FREQ_REF 16'h0023
`define DMRB_ADDR_OUT_FREQ 16'h0024
`define DMRB_ADDR_OUT_VOLT_REF 16'h0025
`define DMRB_ADDR_OUT_CURRENT 16'h0026
`define DMRB_ADDR_OUT_POWER 16'h0027
`define DMRB_ADDR_TORQUE_REF 16'h0028

// drive_run_status fields
`define DMRB_RUN_BIT_RUNNING 0
`define DMRB_RUN_BIT_REVERSE 1
`define DMRB_RUN_BIT_STARTED 2
`define DMRB_RUN_BIT_FAULT 3
`define DMRB_RUN_BIT_SET_ERR 4
`define DMRB_RUN_BIT_RELAY_LO 5
`define DMRB_RUN_BIT_PHOTO_LO 8

// fault_category_flags fields
`define DMRB_FLT_OVERCURRENT 0
`define DMRB_FLT_BUS_HIGH 1
`define DMRB_FLT_DRIVE_OVERLOAD 2
`define DMRB_FLT_OVERHEAT 3
`define DMRB_FLT_BRAKE 4
`define DMRB_FLT_FUSE 5
`define DMRB_FLT_PID_LOST 6
`define DMRB_FLT_EXTERNAL 7
`define DMRB_FLT_HARDWARE 8
`define DMRB_FLT_MOTOR_LOAD 9
`define DMRB_FLT_SPEED 10
`define DMRB_FLT_BUS_LOW 11
`define DMRB_FLT_SUPPLY 12
`define DMRB_FLT_PHASE_OPEN 13
`define DMRB_FLT_SERIAL 14
`define DMRB_FLT_KEYPAD 15

// link_write_status fields
`define DMRB_LINK_BIT_STORING 0
`define DMRB_LINK_BIT_LIMIT 3
`define DMRB_LINK_BIT_INTEGRITY 4

`define DMRB_RESET_WORD 16'h0000

// measured value refresh
`define DMRB_CLK_NS 50
`define DMRB_SAMPLE_NS 1000
`define DMRB_SAMPLE_CYC (`DMRB_SAMPLE_NS / `DMRB_CLK_NS)
`define DMRB_SAMPLE_CNT_W 5

`endif

// ### hdl/dmrb_fault_if.sv
/*
 * carrier between the bank top and its fault category mapper.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface dmrb_fault_if;
  dmrb_pkg::dmrb_trip_s trip;
  dmrb_pkg::dmrb_word_t category;
  modport mapper (input trip, output category);
  modport owner (output trip, input category);
endinterface

// ### hdl/dmrb_fault_map.sv
/*
 * folds individual trip sources into the sixteen fault categories.
 * assumes sources are same-clock logic levels; purely combinational.
 */
`timescale 1ns/100ps
`include "dmrb_cfg.svh"
module dmrb_fault_map (
  dmrb_fault_if.mapper flt
);

  always_comb begin
    flt.category = `DMRB_RESET_WORD;
    flt.category[`DMRB_FLT_OVERCURRENT] = flt.trip.overcurrent | flt.trip.ground_leak;
    flt.category[`DMRB_FLT_BUS_HIGH] = flt.trip.bus_high;
    flt.category[`DMRB_FLT_DRIVE_OVERLOAD] = flt.trip.drive_overload;
    flt.category[`DMRB_FLT_OVERHEAT] = flt.trip.hot_one | flt.trip.hot_two;
    flt.category[`DMRB_FLT_BRAKE] = flt.trip.brake_transistor | flt.trip.brake_resistor;
    flt.category[`DMRB_FLT_FUSE] = flt.trip.fuse_open;
    flt.category[`DMRB_FLT_PID_LOST] = flt.trip.pid_lost;
    flt.category[`DMRB_FLT_EXTERNAL] = flt.trip.external | flt.trip.external_link;
    flt.category[`DMRB_FLT_HARDWARE] = flt.trip.hardware;
    flt.category[`DMRB_FLT_MOTOR_LOAD] = flt.trip.motor_overload | flt.trip.overtorque_one
      | flt.trip.overtorque_two;
    flt.category[`DMRB_FLT_SPEED] = flt.trip.encoder_break | flt.trip.overspeed
      | flt.trip.speed_error;
    flt.category[`DMRB_FLT_BUS_LOW] = flt.trip.bus_low;
    flt.category[`DMRB_FLT_SUPPLY] = flt.trip.main_undervolt | flt.trip.control_supply
      | flt.trip.inrush | flt.trip.power_loss;
    flt.category[`DMRB_FLT_PHASE_OPEN] = flt.trip.out_phase_loss | flt.trip.in_phase_loss;
    flt.category[`DMRB_FLT_SERIAL] = flt.trip.serial_error;
    flt.category[`DMRB_FLT_KEYPAD] = flt.trip.keypad_off;
  end

endmodule // dmrb_fault_map

// ### hdl/dmrb_pkg.sv
/*
 * types shared by the drive monitor register bank.
 * assumes nothing beyond a sv compiler.
 */
package dmrb_pkg;

  typedef logic [15:0] dmrb_word_t;

  typedef struct packed {
    logic overcurrent;
    logic ground_leak;
    logic bus_high;
    logic drive_overload;
    logic hot_one;
    logic hot_two;
    logic brake_transistor;
    logic brake_resistor;
    logic fuse_open;
    logic pid_lost;
    logic external;
    logic external_link;
    logic hardware;
    logic motor_overload;
    logic overtorque_one;
    logic overtorque_two;
    logic encoder_break;
    logic overspeed;
    logic speed_error;
    logic bus_low;
    logic main_undervolt;
    logic control_supply;
    logic inrush;
    logic power_loss;
    logic out_phase_loss;
    logic in_phase_loss;
    logic serial_error;
    logic keypad_off;
  } dmrb_trip_s;

  typedef enum logic [1:0] {
    DMRB_RD_IDLE = 2'b00,
    DMRB_RD_ANSWER = 2'b01
  } dmrb_rd_state_e;

endpackage

// ### hdl/dmrb_top.sv
/*
 * read-only monitor register bank of the drive's serial register port:
 * three status words and six measured values, read by register number.
 * assumes every input is logic on clk_sys_i; the master decodes frames
 * and crc elsewhere and hands over bare register reads and writes.
 */
`timescale 1ns/100ps
`include "dmrb_cfg.svh"

// Contract
// - every monitor word is read-only; reads return content, writes change nothing.
// - status bit 0 is 1 while the output runs and 0 while stopped.
// - status bit 1 is 1 in reverse rotation and 0 in forward rotation.
// - status bit 2 is 1 once startup has finished and 0 before that.
// - status bit 3 shows any fault present, bit 4 a data setting error.
// - status bits 5 to 7 mirror the relay outputs, bits 8 and 9 the photocouplers.
// - fault bits 0 to 5 carry overcurrent, overvoltage, overload, heat, brake, fuse.
// - fault bits 6 to A carry pid loss, external, hardware, motor load, speed faults.
// - fault bits B to F carry undervoltage, supply, phase, serial and keypad faults.
// - link bit 0 shows a store in progress, bit 3 a limit error, bit 4 an integrity error.
// - values at 0023H to 0028H are freq ref, out freq, volt ref, current, power, torque.
module dmrb_top (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic run_active_i,
  input wire logic dir_reverse_i,
  input wire logic startup_done_i,
  input wire logic setting_error_i,
  input wire logic [2:0] relay_out_i,
  input wire logic [1:0] photo_out_i,
  input wire logic overcurrent_trip_i,
  input wire logic ground_leak_trip_i,
  input wire logic bus_high_voltage_trip_i,
  input wire logic drive_overload_trip_i,
  input wire logic heatsink_hot_trip_one_i,
  input wire logic heatsink_hot_trip_two_i,
  input wire logic brake_transistor_trip_i,
  input wire logic brake_resistor_hot_i,
  input wire logic fuse_open_trip_i,
  input wire logic pid_feedback_lost_i,
  input wire logic external_trip_i,
  input wire logic external_trip_via_link_i,
  input wire logic hardware_trip_i,
  input wire logic motor_overload_trip_i,
  input wire logic overtorque_one_trip_i,
  input wire logic overtorque_two_trip_i,
  input wire logic encoder_wire_break_i,
  input wire logic overspeed_trip_i,
  input wire logic speed_error_trip_i,
  input wire logic bus_low_voltage_trip_i,
  input wire logic main_undervolt_trip_i,
  input wire logic control_supply_fault_i,
  input wire logic inrush_circuit_fault_i,
  input wire logic power_loss_i,
  input wire logic output_phase_loss_i,
  input wire logic input_phase_loss_i,
  input wire logic serial_comm_error_i,
  input wire logic keypad_unplugged_i,
  input wire logic fault_reset_i,
  input wire logic store_busy_i,
  input wire logic write_start_i,
  input wire logic limit_error_i,
  input wire logic integrity_error_i,
  input wire logic [15:0] freq_ref_monitor_i,
  input wire logic [15:0] out_freq_monitor_i,
  input wire logic [15:0] out_volt_ref_monitor_i,
  input wire logic [15:0] out_current_monitor_i,
  input wire logic [15:0] out_power_monitor_i,
  input wire logic [15:0] torque_ref_monitor_i,
  input wire logic rd_req_i,
  input wire logic [15:0] rd_addr_i,
  input wire logic wr_req_i,
  input wire logic [15:0] wr_addr_i,
  output logic rd_valid_o,
  output logic [15:0] rd_data_o,
  output logic rd_addr_err_o,
  output logic wr_refused_o
);

  localparam logic [`DMRB_SAMPLE_CNT_W-1:0] SAMPLE_LAST =
    `DMRB_SAMPLE_CNT_W'(`DMRB_SAMPLE_CYC - 1);

  dmrb_fault_if flt ();

  dmrb_pkg::dmrb_word_t drive_run_status;
  dmrb_pkg::dmrb_word_t fault_category_flags;
  dmrb_pkg::dmrb_word_t link_write_status;
  dmrb_pkg::dmrb_word_t frequency_reference_value;
  dmrb_pkg::dmrb_word_t output_frequency_value;
  dmrb_pkg::dmrb_word_t output_voltage_ref_value;
  dmrb_pkg::dmrb_word_t output_current_value;
  dmrb_pkg::dmrb_word_t output_power_value;
  dmrb_pkg::dmrb_word_t torque_reference_value;
  dmrb_pkg::dmrb_word_t next_fault_flags;
  dmrb_pkg::dmrb_word_t next_run_status;
  dmrb_pkg::dmrb_word_t next_rd_data;
  dmrb_pkg::dmrb_rd_state_e rd_state;
  dmrb_pkg::dmrb_rd_state_e next_rd_state;
  logic [`DMRB_SAMPLE_CNT_W-1:0] sample_cnt;
  logic sample_en;
  logic limit_flag;
  logic integrity_flag;
  logic rd_mapped;

  // one decode serves both the read mux check and the write refusal
  function automatic logic is_monitor_addr(input logic [15:0] addr);
    is_monitor_addr = (addr >= `DMRB_ADDR_RUN_STATUS) && (addr <= `DMRB_ADDR_TORQUE_REF);
  endfunction

  assign rd_mapped = is_monitor_addr(rd_addr_i);

  always_comb begin
    flt.trip.overcurrent = overcurrent_trip_i;
    flt.trip.ground_leak = ground_leak_trip_i;
    flt.trip.bus_high = bus_high_voltage_trip_i;
    flt.trip.drive_overload = drive_overload_trip_i;
    flt.trip.hot_one = heatsink_hot_trip_one_i;
    flt.trip.hot_two = heatsink_hot_trip_two_i;
    flt.trip.brake_transistor = brake_transistor_trip_i;
    flt.trip.brake_resistor = brake_resistor_hot_i;
    flt.trip.fuse_open = fuse_open_trip_i;
    flt.trip.pid_lost = pid_feedback_lost_i;
    flt.trip.external = external_trip_i;
    flt.trip.external_link = external_trip_via_link_i;
    flt.trip.hardware = hardware_trip_i;
    flt.trip.motor_overload = motor_overload_trip_i;
    flt.trip.overtorque_one = overtorque_one_trip_i;
    flt.trip.overtorque_two = overtorque_two_trip_i;
    flt.trip.encoder_break = encoder_wire_break_i;
    flt.trip.overspeed = overspeed_trip_i;
    flt.trip.speed_error = speed_error_trip_i;
    flt.trip.bus_low = bus_low_voltage_trip_i;
    flt.trip.main_undervolt = main_undervolt_trip_i;
    flt.trip.control_supply = control_supply_fault_i;
    flt.trip.inrush = inrush_circuit_fault_i;
    flt.trip.power_loss = power_loss_i;
    flt.trip.out_phase_loss = output_phase_loss_i;
    flt.trip.in_phase_loss = input_phase_loss_i;
    flt.trip.serial_error = serial_comm_error_i;
    flt.trip.keypad_off = keypad_unplugged_i;
  end

  dmrb_fault_map u_fault_map (
    .flt (flt.mapper)
  );

  // fault categories stay latched until reset; a live trip wins over the reset
  always_comb begin
    next_fault_flags = fault_category_flags;
    if (fault_reset_i) begin
      next_fault_flags = `DMRB_RESET_WORD;
    end
    next_fault_flags = next_fault_flags | flt.category;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_category_flags <= `DMRB_RESET_WORD;
    end else begin
      fault_category_flags <= next_fault_flags;
    end
  end

  // status word; unassigned positions stay zero
  always_comb begin
    next_run_status = `DMRB_RESET_WORD;
    next_run_status[`DMRB_RUN_BIT_RUNNING] = run_active_i;
    next_run_status[`DMRB_RUN_BIT_REVERSE] = dir_reverse_i;
    next_run_status[`DMRB_RUN_BIT_STARTED] = startup_done_i;
    next_run_status[`DMRB_RUN_BIT_FAULT] = |next_fault_flags;
    next_run_status[`DMRB_RUN_BIT_SET_ERR] = setting_error_i;
    next_run_status[`DMRB_RUN_BIT_RELAY_LO +: 3] = relay_out_i;
    next_run_status[`DMRB_RUN_BIT_PHOTO_LO +: 2] = photo_out_i;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_run_status <= `DMRB_RESET_WORD;
    end else begin
      drive_run_status <= next_run_status;
    end
  end

  // link error flags hold until the next write begins; a new error wins
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      limit_flag <= 1'b0;
    end else if (limit_error_i) begin
      limit_flag <= 1'b1;
    end else if (write_start_i) begin
      limit_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      integrity_flag <= 1'b0;
    end else if (integrity_error_i) begin
      integrity_flag <= 1'b1;
    end else if (write_start_i) begin
      integrity_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_write_status <= `DMRB_RESET_WORD;
    end else begin
      link_write_status <= `DMRB_RESET_WORD;
      link_write_status[`DMRB_LINK_BIT_STORING] <= store_busy_i;
      link_write_status[`DMRB_LINK_BIT_LIMIT] <= limit_flag | limit_error_i;
      link_write_status[`DMRB_LINK_BIT_INTEGRITY] <= integrity_flag | integrity_error_i;
    end
  end

  // refresh divider: measured values move together so a poll sees one set
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_cnt <= '0;
    end else if (sample_cnt == SAMPLE_LAST) begin
      sample_cnt <= '0;
    end else begin
      sample_cnt <= sample_cnt + `DMRB_SAMPLE_CNT_W'(1);
    end
  end

  assign sample_en = (sample_cnt == SAMPLE_LAST);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frequency_reference_value <= `DMRB_RESET_WORD;
      output_frequency_value <= `DMRB_RESET_WORD;
      output_voltage_ref_value <= `DMRB_RESET_WORD;
      output_current_value <= `DMRB_RESET_WORD;
      output_power_value <= `DMRB_RESET_WORD;
      torque_reference_value <= `DMRB_RESET_WORD;
    end else if (sample_en) begin
      frequency_reference_value <= freq_ref_monitor_i;
      output_frequency_value <= out_freq_monitor_i;
      output_voltage_ref_value <= out_volt_ref_monitor_i;
      output_current_value <= out_current_monitor_i;
      output_power_value <= out_power_monitor_i;
      torque_reference_value <= torque_ref_monitor_i;
    end
  end

  // read mux; unmapped numbers answer zero plus an address error
  always_comb begin
    case (rd_addr_i)
      `DMRB_ADDR_RUN_STATUS: next_rd_data = drive_run_status;
      `DMRB_ADDR_FAULT_FLAGS: next_rd_data = fault_category_flags;
      `DMRB_ADDR_LINK_STATUS: next_rd_data = link_write_status;
      `DMRB_ADDR_FREQ_REF: next_rd_data = frequency_reference_value;
      `DMRB_ADDR_OUT_FREQ: next_rd_data = output_frequency_value;
      `DMRB_ADDR_OUT_VOLT_REF: next_rd_data = output_voltage_ref_value;
      `DMRB_ADDR_OUT_CURRENT: next_rd_data = output_current_value;
      `DMRB_ADDR_OUT_POWER: next_rd_data = output_power_value;
      `DMRB_ADDR_TORQUE_REF: next_rd_data = torque_reference_value;
      default: next_rd_data = `DMRB_RESET_WORD;
    endcase
  end

  always_comb begin
    case (rd_state)
      dmrb_pkg::DMRB_RD_IDLE: begin
        next_rd_state = rd_req_i ? dmrb_pkg::DMRB_RD_ANSWER : dmrb_pkg::DMRB_RD_IDLE;
      end
      dmrb_pkg::DMRB_RD_ANSWER: begin
        next_rd_state = rd_req_i ? dmrb_pkg::DMRB_RD_ANSWER : dmrb_pkg::DMRB_RD_IDLE;
      end
      default: begin
        next_rd_state = dmrb_pkg::DMRB_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_state <= dmrb_pkg::DMRB_RD_IDLE;
    end else begin
      rd_state <= next_rd_state;
    end
  end

  // data held after the answer so a slow master may sample late
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= `DMRB_RESET_WORD;
      rd_addr_err_o <= 1'b0;
    end else if (rd_req_i) begin
      rd_data_o <= next_rd_data;
      rd_addr_err_o <= !rd_mapped;
    end
  end

  assign rd_valid_o = (rd_state == dmrb_pkg::DMRB_RD_ANSWER);

  // a write to a monitor word is only acknowledged as refused
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_refused_o <= 1'b0;
    end else begin
      wr_refused_o <= wr_req_i && is_monitor_addr(wr_addr_i);
    end
  end

endmodule // dmrb_top

// ### tb/dmrb_master_model.sv
/*
 * register master model: one read, two back-to-back reads or one write per call, falling-edge driven.
 * assumes the bank answers in the cycle after the taking edge.
 */
`timescale 1ns/100ps
module dmrb_master_model (
  input wire logic clk_i,
  input wire logic rd_valid_i,
  input wire logic [15:0] rd_data_i,
  input wire logic rd_addr_err_i,
  input wire logic wr_refused_i,
  output logic rd_req_o,
  output logic [15:0] rd_addr_o,
  output logic wr_req_o,
  output logic [15:0] wr_addr_o
);
  initial begin
    rd_req_o = 1'b0;
    rd_addr_o = 16'hffff;
    wr_req_o = 1'b0;
    wr_addr_o = 16'hffff;
  end
  task automatic rd_word(input logic [15:0] a, output logic [15:0] d, output logic e,
      output logic v);
    @(negedge clk_i);
    rd_req_o = 1'b1;
    rd_addr_o = a;
    @(negedge clk_i);
    rd_req_o = 1'b0;
    rd_addr_o = ~a; // released address shows junk, not the last value
    d = rd_data_i;
    e = rd_addr_err_i;
    v = rd_valid_i;
  endtask
  task automatic rd_two(input logic [15:0] a0, input logic [15:0] a1,
      output logic [15:0] d0, output logic [15:0] d1, output logic v1);
    @(negedge clk_i);
    rd_req_o = 1'b1;
    rd_addr_o = a0;
    @(negedge clk_i);
    rd_addr_o = a1; // strobe held high so the answer state is kept
    d0 = rd_data_i;
    @(negedge clk_i);
    rd_req_o = 1'b0;
    rd_addr_o = ~a1;
    d1 = rd_data_i;
    v1 = rd_valid_i;
  endtask
  task automatic wr_word(input logic [15:0] a, output logic r);
    @(negedge clk_i);
    wr_req_o = 1'b1;
    wr_addr_o = a;
    @(negedge clk_i);
    wr_req_o = 1'b0;
    wr_addr_o = ~a;
    r = wr_refused_i;
  endtask
endmodule // dmrb_master_model

// ### tb/dmrb_top_asserts.sv
/*
 * concurrent checks on the monitor bank's read, write and status behaviour.
 * assumes it is bound into dmrb_top and sees only that module's ports.
 */
`timescale 1ns/100ps
module dmrb_top_asserts (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic run_active_i,
  input wire logic overcurrent_trip_i,
  input wire logic pid_feedback_lost_i,
  input wire logic rd_req_i,
  input wire logic [15:0] rd_addr_i,
  input wire logic wr_req_i,
  input wire logic [15:0] wr_addr_i,
  input wire logic rd_valid_o,
  input wire logic [15:0] rd_data_o,
  input wire logic rd_addr_err_o,
  input wire logic wr_refused_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  logic rd_map;
  logic wr_map;
  assign rd_map = (rd_addr_i >= 16'h0020) && (rd_addr_i <= 16'h0028);
  assign wr_map = (wr_addr_i >= 16'h0020) && (wr_addr_i <= 16'h0028);

  property p_rd_answer;
    rd_req_i |=> rd_valid_o ##1 (rd_valid_o == $past(rd_req_i));
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read strobe wrong");
  property p_rd_quiet;
    !rd_req_i |=> !rd_valid_o && $stable(rd_data_o) && $stable(rd_addr_err_o);
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("answer moved unasked");
  property p_unmapped;
    rd_req_i && !rd_map |=> rd_addr_err_o && (rd_data_o == 16'h0000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read wrong");
  property p_wr_refuse;
    wr_req_i && wr_map |=> wr_refused_o;
  endproperty
  a_wr_refuse: assert property (p_wr_refuse) else $error("write not refused");
  property p_wr_quiet;
    !(wr_req_i && wr_map) |=> !wr_refused_o;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("stray refuse pulse");
  property p_run_bit;
    rd_req_i && (rd_addr_i == 16'h0020) && $past(rst_n_i)
      |=> rd_data_o[0] == $past(run_active_i, 2);
  endproperty
  a_run_bit: assert property (p_run_bit) else $error("run bit wrong");
  property p_fault_bit;
    rd_req_i && (rd_addr_i == 16'h0021) && $past(rst_n_i) && $past(overcurrent_trip_i)
      |=> rd_data_o[0];
  endproperty
  a_fault_bit: assert property (p_fault_bit) else $error("fault bit 0 clear");
  property p_any_fault;
    rd_req_i && (rd_addr_i == 16'h0020) && $past(rst_n_i) && $past(pid_feedback_lost_i)
      |=> rd_data_o[3];
  endproperty
  a_any_fault: assert property (p_any_fault) else $error("fault summary clear");
  property p_unused;
    rd_req_i && (rd_addr_i == 16'h0020) |=> rd_data_o[15:10] == 6'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("status spare bits set");
  property p_link_unused;
    rd_req_i && (rd_addr_i == 16'h0022)
      |=> (rd_data_o[15:5] == 11'h000) && (rd_data_o[2:1] == 2'h0);
  endproperty
  a_link_unused: assert property (p_link_unused) else $error("link spare bits set");
endmodule // dmrb_top_asserts

bind dmrb_top dmrb_top_asserts chk (.clk_sys_i, .rst_n_i, .run_active_i, .overcurrent_trip_i,
  .pid_feedback_lost_i, .rd_req_i, .rd_addr_i, .wr_req_i, .wr_addr_i, .rd_valid_o,
  .rd_data_o, .rd_addr_err_o, .wr_refused_o);

// ### tb/tb_drive_monitor_register_bank.sv
/*
 * self-checking bench of the monitor bank: status, faults, link, values, writes.
 * assumes dmrb_top, its package, interface and the master model are compiled.
 */
`timescale 1ns/100ps
`include "dmrb_cfg.svh"
module tb_drive_monitor_register_bank;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [9:0] st = '0;
  logic [27:0] trp = '0;
  logic fault_reset_i = 1'b0, store_busy_i = 1'b0, write_start_i = 1'b0;
  logic limit_error_i = 1'b0, integrity_error_i = 1'b0;
  logic [15:0] mon [6];
  logic rd_req_i, wr_req_i, rd_valid_o, rd_addr_err_o, wr_refused_o;
  logic [15:0] rd_addr_i, wr_addr_i, rd_data_o, d, d2;
  logic e, v;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int fbit [28] = '{0, 0, 1, 2, 3, 3, 4, 4, 5, 6, 7, 7, 8, 9, 9, 9, 10, 10, 10, 11, 12, 12,
    12, 12, 13, 13, 14, 15};
  logic [15:0] bad [3] = '{16'h001f, 16'h0029, 16'hffff};

  always #25 clk_sys_i = ~clk_sys_i;

  dmrb_top uut (.clk_sys_i, .rst_n_i, .run_active_i(st[0]), .dir_reverse_i(st[1]),
    .startup_done_i(st[2]), .setting_error_i(st[4]), .relay_out_i(st[7:5]),
    .photo_out_i(st[9:8]), .overcurrent_trip_i(trp[0]), .ground_leak_trip_i(trp[1]),
    .bus_high_voltage_trip_i(trp[2]), .drive_overload_trip_i(trp[3]),
    .heatsink_hot_trip_one_i(trp[4]), .heatsink_hot_trip_two_i(trp[5]),
    .brake_transistor_trip_i(trp[6]), .brake_resistor_hot_i(trp[7]),
    .fuse_open_trip_i(trp[8]), .pid_feedback_lost_i(trp[9]), .external_trip_i(trp[10]),
    .external_trip_via_link_i(trp[11]), .hardware_trip_i(trp[12]),
    .motor_overload_trip_i(trp[13]), .overtorque_one_trip_i(trp[14]),
    .overtorque_two_trip_i(trp[15]), .encoder_wire_break_i(trp[16]),
    .overspeed_trip_i(trp[17]), .speed_error_trip_i(trp[18]),
    .bus_low_voltage_trip_i(trp[19]), .main_undervolt_trip_i(trp[20]),
    .control_supply_fault_i(trp[21]), .inrush_circuit_fault_i(trp[22]),
    .power_loss_i(trp[23]), .output_phase_loss_i(trp[24]), .input_phase_loss_i(trp[25]),
    .serial_comm_error_i(trp[26]), .keypad_unplugged_i(trp[27]), .fault_reset_i,
    .store_busy_i, .write_start_i, .limit_error_i, .integrity_error_i,
    .freq_ref_monitor_i(mon[0]), .out_freq_monitor_i(mon[1]), .out_volt_ref_monitor_i(mon[2]),
    .out_current_monitor_i(mon[3]), .out_power_monitor_i(mon[4]),
    .torque_ref_monitor_i(mon[5]), .rd_req_i, .rd_addr_i, .wr_req_i, .wr_addr_i,
    .rd_valid_o, .rd_data_o, .rd_addr_err_o, .wr_refused_o);

  dmrb_master_model mst (.clk_i(clk_sys_i), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
    .rd_addr_err_i(rd_addr_err_o), .wr_refused_i(wr_refused_o), .rd_req_o(rd_req_i),
    .rd_addr_o(rd_addr_i), .wr_req_o(wr_req_i), .wr_addr_o(wr_addr_i));

  task automatic chk_word(input string what, input logic [15:0] x, input logic [15:0] g);
    n_compared++;
    if (g !== x) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, x, g);
    end
  endtask
  task automatic chk_bit(input string what, input logic x, input logic g);
    n_compared++;
    if (g !== x) begin
      err_total++;
      $display("Error %s expected %b seen %b", what, x, g);
    end
  endtask
  task automatic rd_chk(input string what, input logic [15:0] a, input logic [15:0] x);
    mst.rd_word(a, d, e, v);
    chk_bit("rd_valid_o", 1'b1, v);
    chk_bit("rd_addr_err_o", 1'b0, e);
    chk_word(what, x, d);
  endtask
  task automatic pulse_clear;
    fault_reset_i = 1'b1;
    @(negedge clk_sys_i);
    fault_reset_i = 1'b0;
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    for (int i = 0; i < 6; i++) mon[i] = 16'h0000;
    repeat (6) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    for (int k = 0; k < 10; k++) begin
      st = (k == 3) ? 10'h000 : 10'h001 << k;
      rd_chk("drive_run_status", 16'h0020, {6'h00, st});
    end
    st = 10'h000;
    for (int i = 0; i < 28; i++) begin
      trp[i] = 1'b1;
      rd_chk("drive_run_status", 16'h0020, 16'h0008);
      rd_chk("fault_category_flags", 16'h0021, 16'h0001 << fbit[i]);
      trp[i] = 1'b0;
      rd_chk("fault_category_flags", 16'h0021, 16'h0001 << fbit[i]);
      pulse_clear();
      rd_chk("fault_category_flags", 16'h0021, 16'h0000);
    end
    trp[27] = 1'b1;
    pulse_clear();
    trp[27] = 1'b0;
    rd_chk("fault_category_flags", 16'h0021, 16'h8000);
    pulse_clear();
    store_busy_i = 1'b1;
    rd_chk("link_write_status", 16'h0022, 16'h0001);
    store_busy_i = 1'b0;
    limit_error_i = 1'b1;
    @(negedge clk_sys_i);
    limit_error_i = 1'b0;
    rd_chk("link_write_status", 16'h0022, 16'h0008);
    integrity_error_i = 1'b1;
    write_start_i = 1'b1;
    @(negedge clk_sys_i);
    integrity_error_i = 1'b0;
    write_start_i = 1'b0;
    rd_chk("link_write_status", 16'h0022, 16'h0010);
    for (int i = 0; i < 6; i++) mon[i] = 16'(16'h1111 * (i + 1));
    repeat (`DMRB_SAMPLE_CYC + 2) @(negedge clk_sys_i);
    for (int i = 0; i < 6; i++) begin
      rd_chk("monitor value", 16'(16'h0023 + i), mon[i]);
    end
    for (int a = 16'h001f; a <= 16'h0029; a++) begin
      mst.wr_word(16'(a), e);
      chk_bit("wr_refused_o", (a >= 16'h0020) && (a <= 16'h0028), e);
    end
    rd_chk("link_write_status", 16'h0022, 16'h0010);
    rd_chk("output_power_value", 16'h0027, mon[4]);
    mst.rd_two(16'h0027, 16'h0028, d, d2, v);
    chk_word("output_power_value", mon[4], d);
    chk_word("torque_reference_value", mon[5], d2);
    chk_bit("rd_valid_o", 1'b1, v);
    foreach (bad[i]) begin
      mst.rd_word(bad[i], d, e, v);
      chk_word("unmapped data", 16'h0000, d);
      chk_bit("unmapped flag", 1'b1, e);
      chk_bit("unmapped valid", 1'b1, v);
    end
    close_out();
  end
endmodule // tb_drive_monitor_register_bank
